// File: asq_pkg.sv
// Register map, field layout, states and helpers of the sample sequencer control
package asq_pkg;
  localparam int          NSEQ        = 4;
  localparam int          RES_W       = 10;
  localparam int          ADR_W       = 12;
  localparam int          ACC_W       = 16;
  // Register byte offsets
  localparam logic [11:0] OFF_ENABLE  = 12'h000;
  localparam logic [11:0] OFF_RAW     = 12'h004;
  localparam logic [11:0] OFF_MASK    = 12'h008;
  localparam logic [11:0] OFF_ISC     = 12'h00c;
  localparam logic [11:0] OFF_OVF     = 12'h010;
  localparam logic [11:0] OFF_TRIG    = 12'h014;
  localparam logic [11:0] OFF_UDF     = 12'h018;
  localparam logic [11:0] OFF_PRI     = 12'h020;
  localparam logic [11:0] OFF_INIT    = 12'h028;
  localparam logic [11:0] OFF_AVG     = 12'h030;
  localparam logic [11:0] SEQ_BASE    = 12'h040;
  localparam logic [11:0] SEQ_END     = 12'h0c0;
  localparam logic [4:0]  SEQ_MUX     = 5'h00;
  localparam logic [4:0]  SEQ_CTL     = 5'h04;
  localparam logic [4:0]  SEQ_FIFO    = 5'h08;
  localparam logic [4:0]  SEQ_FSTAT   = 5'h0c;
  // Reset values
  localparam logic [15:0] PRI_RST     = 16'h3210;
  localparam logic [31:0] CTL3_RST    = 32'h0000_0002;
  // Step control nibble bits
  localparam int          CTL_DIFF    = 0;
  localparam int          CTL_END     = 1;
  localparam int          CTL_IE      = 2;
  localparam int          CTL_TS      = 3;
  // FIFO status fields
  localparam int          FST_TAIL    = 0;
  localparam int          FST_HEAD    = 4;
  localparam int          FST_EMPTY   = 8;
  localparam int          FST_FULL    = 12;
  // Trigger source codes and averaging limit
  localparam logic [3:0]  TRIG_PROC   = 4'h0;
  localparam logic [3:0]  TRIG_ALWAYS = 4'hf;
  localparam logic [2:0]  AVG_MAX_LOG = 3'h6;
  // Clock rates
  localparam logic [31:0] SYS_HZ      = 32'd25_000_000;
  localparam logic [31:0] CONV_HZ     = 32'd16_667_000;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_WAIT  = 4'b0100,
    ST_STORE = 4'b1000
  } asq_state_t;

  function automatic logic [3:0] seq_depth(input logic [1:0] s);
    case (s)
      2'h0:    seq_depth = 4'h8;
      2'h3:    seq_depth = 4'h1;
      default: seq_depth = 4'h4;
    endcase
  endfunction

  function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    byte_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        byte_merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction
endpackage

// File: asq_core.sv
// Sample sequencer control: four sequencers, result FIFOs, arbitration, averaging, Wishbone registers
`timescale 1ns/10ps
module asq_core #(
  parameter int          NEVT   = 4,
  parameter logic [31:0] CLK_HZ = asq_pkg::SYS_HZ,
  parameter logic [31:0] ADC_HZ = asq_pkg::CONV_HZ
) (
  // Clock and reset
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst,
  // Wishbone slave
  input  wire logic                      i_wb_cyc,
  input  wire logic                      i_wb_stb,
  input  wire logic                      i_wb_we,
  input  wire logic [asq_pkg::ADR_W-1:0] i_wb_adr,
  input  wire logic [3:0]                i_wb_sel,
  input  wire logic [31:0]               i_wb_dat,
  output logic      [31:0]               o_wb_dat,
  output logic                           o_wb_ack,
  // Peripheral trigger events
  input  wire logic [NEVT-1:0]           i_evt_trig,
  // Converter core
  output logic                           o_conv_start,
  output logic      [2:0]                o_conv_pos,
  output logic      [2:0]                o_conv_neg,
  output logic                           o_conv_diff,
  output logic                           o_conv_temp,
  input  wire logic                      i_conv_done,
  input  wire logic [asq_pkg::RES_W-1:0] i_conv_data,
  // Per-sequencer interrupts
  output logic      [asq_pkg::NSEQ-1:0]  o_irq
);
  import asq_pkg::*;

  logic [NSEQ-1:0]  en_q, raw_q, mask_q, ovf_q, udf_q, pend_q;
  logic [15:0]      trig_q, pri_q;
  logic [2:0]       avg_q;
  logic [31:0]      mux_q [NSEQ];
  logic [31:0]      ctl_q [NSEQ];
  logic [RES_W-1:0] mem_q [NSEQ][8];
  logic [2:0]       wp_q  [NSEQ];
  logic [2:0]       rp_q  [NSEQ];
  logic [3:0]       cnt_q [NSEQ];
  asq_state_t       st_q;
  logic [1:0]       cur_q;
  logic [2:0]       step_q;
  logic [6:0]       nsmp_q;
  logic [ACC_W-1:0] acc_q;
  logic [31:0]      frac_q;
  logic             tick_q;
  logic [31:0]      rdat_d;

  // Bus decode; a request is taken once, ack follows one cycle later
  wire              take    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire              wr      = take & i_wb_we;
  wire              rd      = take & ~i_wb_we;
  wire              in_seq  = (i_wb_adr >= SEQ_BASE) && (i_wb_adr < SEQ_END);
  wire [11:0]       seq_rel = i_wb_adr - SEQ_BASE;
  wire [1:0]        sidx    = seq_rel[6:5];
  wire [4:0]        soff    = seq_rel[4:0];
  wire [31:0]       lane_m  = byte_merge(32'h0, 32'hffff_ffff, i_wb_sel);
  wire [31:0]       wbits   = i_wb_dat & lane_m;
  wire [NSEQ-1:0]   isc_clr = (wr && i_wb_adr == OFF_ISC) ? wbits[NSEQ-1:0] : '0;
  wire [NSEQ-1:0]   ovf_clr = (wr && i_wb_adr == OFF_OVF) ? wbits[NSEQ-1:0] : '0;
  wire [NSEQ-1:0]   udf_clr = (wr && i_wb_adr == OFF_UDF) ? wbits[NSEQ-1:0] : '0;
  wire [NSEQ-1:0]   init    = (wr && i_wb_adr == OFF_INIT) ? wbits[NSEQ-1:0] : '0;

  // Current step fields
  wire [3:0]        cur_mux = mux_q[cur_q][{step_q, 2'b00} +: 4];
  wire [3:0]        cur_ctl = ctl_q[cur_q][{step_q, 2'b00} +: 4];
  wire [2:0]        avg_log = (avg_q > AVG_MAX_LOG) ? AVG_MAX_LOG : avg_q;
  wire [6:0]        avg_cnt = 7'h1 << avg_log;
  wire [3:0]        cur_dep = seq_depth(cur_q);
  wire              last    = cur_ctl[CTL_END] || ({1'b0, step_q} == cur_dep - 4'h1);
  wire              step_ok = (st_q == ST_STORE) && tick_q && (nsmp_q >= avg_cnt);
  wire [RES_W-1:0]  avg_res = RES_W'(acc_q >> avg_log);

  // Trigger sources and priority pick
  logic [NSEQ-1:0]  trig;
  logic [NSEQ-1:0]  pop, push, full, empty;
  logic [1:0]       pick;
  logic             pick_v;
  logic [1:0]       best_pri;

  always_comb begin
    for (int s = 0; s < NSEQ; s++) begin
      if (trig_q[s*4 +: 4] == TRIG_PROC) begin
        trig[s] = init[s];
      end else if (trig_q[s*4 +: 4] == TRIG_ALWAYS) begin
        trig[s] = 1'b1;
      end else if (int'(trig_q[s*4 +: 4]) <= NEVT) begin
        trig[s] = i_evt_trig[int'(trig_q[s*4 +: 4]) - 1];
      end else begin
        trig[s] = 1'b0;
      end
    end
  end

  always_comb begin
    pick     = '0;
    pick_v   = 1'b0;
    best_pri = '0;
    for (int s = 0; s < NSEQ; s++) begin
      if (pend_q[s] && en_q[s] && (!pick_v || pri_q[s*4 +: 2] < best_pri)) begin
        pick     = 2'(s);
        pick_v   = 1'b1;
        best_pri = pri_q[s*4 +: 2];
      end
    end
  end

  wire              grant   = (st_q == ST_IDLE) && tick_q && pick_v;

  always_comb begin
    for (int s = 0; s < NSEQ; s++) begin
      full[s]  = cnt_q[s] == seq_depth(2'(s));
      empty[s] = cnt_q[s] == 4'h0;
      pop[s]   = rd && in_seq && sidx == 2'(s) && soff == SEQ_FIFO;
      push[s]  = step_ok && cur_q == 2'(s);
    end
  end

  // Fractional divider: converter pace enable near ADC_HZ
  wire [31:0]       frac_sum = frac_q + ADC_HZ;
  wire              frac_hit = frac_sum >= CLK_HZ;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      frac_q <= '0;
      tick_q <= 1'b0;
    end else begin
      frac_q <= frac_hit ? frac_sum - CLK_HZ : frac_sum;
      tick_q <= frac_hit;
    end
  end

  // Sequencing state machine
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_q         <= ST_IDLE;
      cur_q        <= '0;
      step_q       <= '0;
      nsmp_q       <= '0;
      acc_q        <= '0;
      o_conv_start <= 1'b0;
      o_conv_pos   <= '0;
      o_conv_neg   <= '0;
      o_conv_diff  <= 1'b0;
      o_conv_temp  <= 1'b0;
    end else begin
      o_conv_start <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (grant) begin
            cur_q  <= pick;
            step_q <= '0;
            nsmp_q <= '0;
            acc_q  <= '0;
            st_q   <= ST_START;
          end
        end
        ST_START: begin
          if (tick_q) begin
            o_conv_start <= 1'b1;
            o_conv_diff  <= cur_ctl[CTL_DIFF];
            o_conv_temp  <= cur_ctl[CTL_TS];
            o_conv_pos   <= cur_ctl[CTL_DIFF] ? {cur_mux[1:0], 1'b0} : cur_mux[2:0];
            o_conv_neg   <= cur_ctl[CTL_DIFF] ? {cur_mux[1:0], 1'b1} : 3'h0;
            st_q         <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (i_conv_done) begin
            acc_q  <= acc_q + ACC_W'(i_conv_data);
            nsmp_q <= nsmp_q + 7'h1;
            st_q   <= ST_STORE;
          end
        end
        ST_STORE: begin
          if (tick_q) begin
            if (nsmp_q < avg_cnt) begin
              st_q <= ST_START;
            end else if (last || !en_q[cur_q]) begin
              st_q <= ST_IDLE;
            end else begin
              step_q <= step_q + 3'h1;
              nsmp_q <= '0;
              acc_q  <= '0;
              st_q   <= ST_START;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Result FIFOs; a result into a full FIFO is dropped
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      for (int s = 0; s < NSEQ; s++) begin
        wp_q[s]  <= '0;
        rp_q[s]  <= '0;
        cnt_q[s] <= '0;
      end
    end else begin
      for (int s = 0; s < NSEQ; s++) begin
        if (push[s] && !full[s]) begin
          mem_q[s][wp_q[s]] <= avg_res;
          wp_q[s]           <= ({1'b0, wp_q[s]} == seq_depth(2'(s)) - 4'h1) ? 3'h0 : wp_q[s] + 3'h1;
        end
        if (pop[s] && !empty[s]) begin
          rp_q[s] <= ({1'b0, rp_q[s]} == seq_depth(2'(s)) - 4'h1) ? 3'h0 : rp_q[s] + 3'h1;
        end
        cnt_q[s] <= cnt_q[s] + 4'((push[s] && !full[s]) ? 1 : 0) - 4'((pop[s] && !empty[s]) ? 1 : 0);
      end
    end
  end

  // Status flags: a set in the same cycle as a clear wins
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      raw_q  <= '0;
      ovf_q  <= '0;
      udf_q  <= '0;
      pend_q <= '0;
      o_irq  <= '0;
    end else begin
      raw_q  <= (raw_q & ~isc_clr) | (push & {NSEQ{cur_ctl[CTL_IE]}});
      ovf_q  <= (ovf_q & ~ovf_clr) | (push & full);
      udf_q  <= (udf_q & ~udf_clr) | (pop & empty);
      pend_q <= ((pend_q & ~(grant ? (4'h1 << pick) : 4'h0)) | trig) & en_q;
      o_irq  <= raw_q & mask_q;
    end
  end

  // Software registers
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      en_q   <= '0;
      mask_q <= '0;
      trig_q <= '0;
      pri_q  <= PRI_RST;
      avg_q  <= '0;
      for (int s = 0; s < NSEQ; s++) begin
        mux_q[s] <= '0;
        ctl_q[s] <= (s == NSEQ - 1) ? CTL3_RST : 32'h0;
      end
    end else if (wr) begin
      if (i_wb_adr == OFF_ENABLE) begin
        en_q <= (en_q & ~lane_m[NSEQ-1:0]) | wbits[NSEQ-1:0];
      end else if (i_wb_adr == OFF_MASK) begin
        mask_q <= (mask_q & ~lane_m[NSEQ-1:0]) | wbits[NSEQ-1:0];
      end else if (i_wb_adr == OFF_TRIG) begin
        trig_q <= (trig_q & ~lane_m[15:0]) | wbits[15:0];
      end else if (i_wb_adr == OFF_PRI) begin
        pri_q <= ((pri_q & ~lane_m[15:0]) | wbits[15:0]) & 16'h3333;
      end else if (i_wb_adr == OFF_AVG) begin
        avg_q <= (avg_q & ~lane_m[2:0]) | wbits[2:0];
      end else if (in_seq && soff == SEQ_MUX) begin
        mux_q[sidx] <= byte_merge(mux_q[sidx], i_wb_dat, i_wb_sel);
      end else if (in_seq && soff == SEQ_CTL) begin
        ctl_q[sidx] <= byte_merge(ctl_q[sidx], i_wb_dat, i_wb_sel);
      end
    end
  end

  // Read mux; unmapped and write-only addresses read zero
  always_comb begin
    rdat_d = 32'h0;
    if (i_wb_adr == OFF_ENABLE) begin
      rdat_d[NSEQ-1:0] = en_q;
    end else if (i_wb_adr == OFF_RAW) begin
      rdat_d[NSEQ-1:0] = raw_q;
    end else if (i_wb_adr == OFF_MASK) begin
      rdat_d[NSEQ-1:0] = mask_q;
    end else if (i_wb_adr == OFF_ISC) begin
      rdat_d[NSEQ-1:0] = raw_q & mask_q;
    end else if (i_wb_adr == OFF_OVF) begin
      rdat_d[NSEQ-1:0] = ovf_q;
    end else if (i_wb_adr == OFF_TRIG) begin
      rdat_d[15:0] = trig_q;
    end else if (i_wb_adr == OFF_UDF) begin
      rdat_d[NSEQ-1:0] = udf_q;
    end else if (i_wb_adr == OFF_PRI) begin
      rdat_d[15:0] = pri_q;
    end else if (i_wb_adr == OFF_AVG) begin
      rdat_d[2:0] = avg_q;
    end else if (in_seq && soff == SEQ_MUX) begin
      rdat_d = mux_q[sidx];
    end else if (in_seq && soff == SEQ_CTL) begin
      rdat_d = ctl_q[sidx];
    end else if (in_seq && soff == SEQ_FIFO && !empty[sidx]) begin
      rdat_d[RES_W-1:0] = mem_q[sidx][rp_q[sidx]];
    end else if (in_seq && soff == SEQ_FSTAT) begin
      rdat_d[FST_TAIL +: 3] = rp_q[sidx];
      rdat_d[FST_HEAD +: 3] = wp_q[sidx];
      rdat_d[FST_EMPTY]     = empty[sidx];
      rdat_d[FST_FULL]      = full[sidx];
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= take;
      if (rd) begin
        o_wb_dat <= rdat_d;
      end
    end
  end

  // Checks
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_run_enable;
    grant |-> en_q[pick] ##1 (st_q == ST_START);
  endproperty
  a_run_enable: assert property (p_run_enable) else $error("sequence started while disabled");

  property p_step_irq;
    (step_ok && cur_ctl[CTL_IE]) |=> raw_q[$past(cur_q)];
  endproperty
  a_step_irq: assert property (p_step_irq) else $error("step interrupt not raised");

  property p_end_stop;
    (step_ok && cur_ctl[CTL_END]) |=> (st_q == ST_IDLE) ##1 !o_conv_start;
  endproperty
  a_end_stop: assert property (p_end_stop) else $error("sequence ran past end step");

  property p_pop_fifo;
    (pop[0] && !empty[0] && !push[0]) |=> (cnt_q[0] == $past(cnt_q[0]) - 4'h1);
  endproperty
  a_pop_fifo: assert property (p_pop_fifo) else $error("read did not remove entry");

  property p_overflow;
    (step_ok && full[cur_q] && !pop[cur_q]) |=> ovf_q[$past(cur_q)] && (cnt_q[$past(cur_q)] == seq_depth($past(cur_q)));
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_underflow;
    (pop[0] && empty[0]) |=> udf_q[0] ##1 (o_wb_dat[RES_W-1:0] == '0);
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow not flagged");

  property p_isc_read;
    (rd && i_wb_adr == OFF_ISC) |=> o_wb_ack && (o_wb_dat[NSEQ-1:0] == $past(raw_q & mask_q));
  endproperty
  a_isc_read: assert property (p_isc_read) else $error("masked status wrong");

  property p_w1c;
    (isc_clr[0] && !push[0]) |=> !raw_q[0] ##1 !o_irq[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_mask_gate;
    !mask_q[0] [*2] |-> !o_irq[0];
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("masked interrupt forwarded");

  c_seq_end:  cover property (step_ok && cur_ctl[CTL_END]);
  c_overflow: cover property (step_ok && full[cur_q]);
  c_avg_push: cover property (step_ok && avg_log != 3'h0);
  c_prio:     cover property (grant && $countones(pend_q & en_q) > 1);
endmodule

// File: asq_conv_model.sv
// Behavioural converter core that answers start pulses after a short or long delay
`timescale 1ns/10ps
module asq_conv_model (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // Conversion request
  input  wire logic       i_start,
  input  wire logic [2:0] i_pos,
  input  wire logic [2:0] i_neg,
  input  wire logic       i_diff,
  input  wire logic       i_temp,
  input  wire logic       i_slow,
  // Result
  output logic            o_done,
  output logic      [9:0] o_data
);
  logic [3:0] cnt_q;
  logic [9:0] res_q;

  // Code names the sampled inputs so the bench can tell steps apart
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_q  <= 4'h0;
      res_q  <= 10'h000;
      o_done <= 1'b0;
      o_data <= 10'h155;
    end else begin
      o_done <= 1'b0;
      // Data is only valid with done, so it toggles otherwise
      o_data <= ~o_data;
      if (i_start) begin
        cnt_q <= i_slow ? 4'h9 : 4'h1;
        res_q <= i_temp ? 10'h2aa : {i_diff, 1'b0, i_pos, i_neg, 2'b01};
      end else if (cnt_q == 4'h1) begin
        cnt_q  <= 4'h0;
        o_done <= 1'b1;
        o_data <= res_q;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

// File: asq_core_tb.sv
// Self-checking bench for the sample sequencer control
`timescale 1ns/10ps
module asq_core_tb;
  import asq_pkg::*;
  localparam logic [11:0] RA[15] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h020,
                                     12'h030, 12'h04c, 12'h06c, 12'h08c, 12'h0ac, 12'h0a4, 12'h0fc};
  localparam logic [31:0] RV[15] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h3210,
                                     32'h0, 32'h100, 32'h100, 32'h100, 32'h100, 32'h2, 32'h0};
  logic        clk, rst, cyc, stb, wr, ack, start, diff, temp, done, slow;
  logic [11:0] adr;
  logic [3:0]  sel, evt, irq;
  logic [31:0] wdat, rdat, q;
  logic [2:0]  pos, neg;
  logic [9:0]  cdat;
  logic [2:0]  pos_q[$];
  int          err_count, n_compared;

  asq_core dut_u (.i_clk_sys(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(wr), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_evt_trig(evt), .o_conv_start(start),
    .o_conv_pos(pos), .o_conv_neg(neg), .o_conv_diff(diff), .o_conv_temp(temp), .i_conv_done(done),
    .i_conv_data(cdat), .o_irq(irq));
  asq_conv_model conv_u (.i_clk_sys(clk), .i_rst(rst), .i_start(start), .i_pos(pos), .i_neg(neg),
    .i_diff(diff), .i_temp(temp), .i_slow(slow), .o_done(done), .o_data(cdat));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (start === 1'b1) pos_q.push_back(pos);
  end

  function automatic logic [31:0] se(input logic [2:0] p, input logic [2:0] n, input logic d);
    se = {22'h0, d, 1'b0, p, n, 2'b01};
  endfunction

  task automatic chk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("ERROR reg %h expected %h seen %h", a, e, g);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    wr   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    wr  <= 1'b0;
    if (n >= 20) chk(a, 32'h1, 32'h0);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(a, e, q);
  endtask

  task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    for (int i = 0; i < 200; i++) begin
      wb(1'b0, a, 32'h0);
      if ((q & m) === e) break;
    end
    chk(a, e, q & m);
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Whole run needs a few hundred cycles
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    finish_test;
  end

  initial begin
    int n;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    wr = 1'b0;
    adr = 12'h000;
    sel = 4'hf;
    wdat = 32'h0;
    evt = 4'h0;
    slow = 1'b0;
    err_count = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wb(1'b1, 12'h0fc, 32'hffff_ffff);
    for (int i = 0; i < 15; i++) rc(RA[i], RV[i]);
    // Four steps with a repeated input, a sensor step, end on the fourth
    wb(1'b1, 12'h040, 32'h5033);
    wb(1'b1, 12'h044, 32'h6804);
    wb(1'b1, OFF_ENABLE, 32'h1);
    wb(1'b1, OFF_INIT, 32'h1);
    poll(12'h04c, 32'hffff_ffff, 32'h40);
    rc(OFF_RAW, 32'h1);
    rc(OFF_ISC, 32'h0);
    chk(12'hfff, 32'h0, {28'h0, irq});
    wb(1'b1, OFF_MASK, 32'h1);
    rc(OFF_ISC, 32'h1);
    chk(12'hfff, 32'h1, {28'h0, irq});
    wb(1'b1, OFF_ISC, 32'h0);
    rc(OFF_RAW, 32'h1);
    wb(1'b1, OFF_ISC, 32'h1);
    rc(OFF_RAW, 32'h0);
    chk(12'hfff, 32'h0, {28'h0, irq});
    rc(12'h048, se(3'h3, 3'h0, 1'b0));
    rc(12'h048, se(3'h3, 3'h0, 1'b0));
    rc(12'h048, 32'h2aa);
    rc(12'h048, se(3'h5, 3'h0, 1'b0));
    rc(12'h04c, 32'h144);
    rc(12'h048, 32'h0);
    rc(OFF_UDF, 32'h1);
    wb(1'b1, OFF_UDF, 32'h1);
    rc(OFF_UDF, 32'h0);
    // Disabled sequencer ignores its initiate bit
    wb(1'b1, OFF_ENABLE, 32'h0);
    wb(1'b1, OFF_INIT, 32'h1);
    repeat (40) @(posedge clk);
    chk(12'hffe, 32'd4, 32'(pos_q.size()));
    // Simultaneous start, sequencer two ranked above one, both differential
    wb(1'b1, OFF_PRI, 32'h3120);
    wb(1'b1, 12'h060, 32'h2);
    wb(1'b1, 12'h064, 32'h3);
    wb(1'b1, 12'h080, 32'h1);
    wb(1'b1, 12'h084, 32'h3);
    wb(1'b1, OFF_ENABLE, 32'h6);
    wb(1'b1, OFF_INIT, 32'h6);
    poll(12'h06c, 32'h100, 32'h0);
    poll(12'h08c, 32'h100, 32'h0);
    chk(12'hffe, 32'h2, {29'h0, pos_q[4]});
    rc(12'h068, se(3'h4, 3'h5, 1'b1));
    rc(12'h088, se(3'h2, 3'h3, 1'b1));
    // Single-entry FIFO overflows on a second result
    wb(1'b1, 12'h0a0, 32'h7);
    wb(1'b1, OFF_ENABLE, 32'h8);
    wb(1'b1, OFF_INIT, 32'h8);
    poll(12'h0ac, 32'h1000, 32'h1000);
    wb(1'b1, OFF_INIT, 32'h8);
    poll(OFF_OVF, 32'hf, 32'h8);
    rc(12'h0a8, se(3'h7, 3'h0, 1'b0));
    wb(1'b1, OFF_OVF, 32'h8);
    rc(OFF_OVF, 32'h0);
    // Free-running trigger refills and overflows again
    wb(1'b1, OFF_TRIG, 32'hf000);
    poll(OFF_OVF, 32'hf, 32'h8);
    wb(1'b1, OFF_ENABLE, 32'h0);
    // Peripheral event two starts sequencer one
    wb(1'b1, OFF_TRIG, 32'h20);
    wb(1'b1, 12'h060, 32'h6);
    wb(1'b1, 12'h064, 32'h2);
    wb(1'b1, OFF_ENABLE, 32'h2);
    @(posedge clk);
    evt <= 4'h2;
    @(posedge clk);
    evt <= 4'h0;
    poll(12'h06c, 32'h100, 32'h0);
    rc(12'h068, se(3'h6, 3'h0, 1'b0));
    // Four-sample averaging with a slow converter
    wb(1'b1, OFF_TRIG, 32'h0);
    wb(1'b1, 12'h080, 32'h4);
    wb(1'b1, 12'h084, 32'h2);
    wb(1'b1, OFF_AVG, 32'h2);
    wb(1'b1, OFF_ENABLE, 32'h4);
    slow <= 1'b1;
    n = pos_q.size();
    wb(1'b1, OFF_INIT, 32'h4);
    poll(12'h08c, 32'h100, 32'h0);
    chk(12'hffd, 32'(n + 4), 32'(pos_q.size()));
    rc(12'h088, se(3'h4, 3'h0, 1'b0));
    finish_test;
  end
endmodule
